// [logic/dph_defs.svh]
`ifndef DPH_DEFS_SVH
`define DPH_DEFS_SVH

// Port geometry
`define DPH_ADDR_W 14
`define DPH_DATA_W 16
`define DPH_RDS_W 3

// Byte lane enables, bit 1 is the high byte
`define DPH_BE_NONE 2'h0
`define DPH_BE_LOW 2'h1
`define DPH_BE_HIGH 2'h2
`define DPH_BE_WORD 2'h3

// Serial command byte layout
`define DPH_SPI_WR_BIT 7
`define DPH_SPI_AHI_W 6
`define DPH_SPI_LAST_BIT 3'h7

// Serial default mode 3
`define DPH_SPI_CPOL_DEF 1'h1
`define DPH_SPI_CPHA_DEF 1'h1

`endif

// [logic/dph_pkg.sv]
package dph_pkg;

    // Parallel read sequencer
    typedef enum logic [1:0] {
        DPH_RD_IDLE = 2'b00,
        DPH_RD_MEM = 2'b01,
        DPH_RD_DLY = 2'b10,
        DPH_RD_DONE = 2'b11
    } dph_rd_e;

    // Serial byte position within a frame
    typedef enum logic [1:0] {
        DPH_SPI_CMD = 2'b00,
        DPH_SPI_ADDR = 2'b01,
        DPH_SPI_DATA = 2'b10
    } dph_spi_e;

    // Memory port owner in the current cycle
    typedef enum logic [2:0] {
        DPH_GNT_NONE = 3'b000,
        DPH_GNT_INT = 3'b001,
        DPH_GNT_SPI = 3'b010,
        DPH_GNT_PW = 3'b011,
        DPH_GNT_PRD = 3'b100
    } dph_gnt_e;

endpackage

// [logic/dph_ram.sv]
`timescale 1ns/10ps

module dph_ram #(
    parameter int AW = 13,
    parameter int DW = 16
) (
    input wire logic clk, // System clock
    input wire logic en, // Access this cycle
    input wire logic we, // Write when high
    input wire logic [1:0] be, // Byte lane enables
    input wire logic [AW-1:0] addr, // Word address
    input wire logic [DW-1:0] wdata, // Write data
    output logic [DW-1:0] rdata // Registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // One access per cycle, read data registered
    always_ff @(posedge clk) begin
        if (en && we && be[0]) begin
            mem[addr][DW/2-1:0] <= wdata[DW/2-1:0];
        end
        if (en && we && be[1]) begin
            mem[addr][DW-1:DW/2] <= wdata[DW-1:DW/2];
        end
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end
endmodule

// [logic/dph_port.sv]
`timescale 1ns/10ps
`include "dph_defs.svh"

module dph_port #(
    parameter int AW = `DPH_ADDR_W,
    parameter int DW = `DPH_DATA_W
) (
    input wire logic clk, // 250 MHz system clock
    input wire logic reset_n, // Async reset, active low
    input wire logic chip_select_n, // Parallel chip select
    input wire logic read_strobe_n, // Parallel read strobe
    input wire logic write_strobe_n, // Parallel write strobe
    input wire logic byte_high_enable_n, // High byte enable
    input wire logic low_address_bit, // Byte address bit 0
    input wire logic [AW-1:1] address, // Word address
    input wire logic [DW-1:0] data_in, // Data bus input
    output logic [DW-1:0] data_out, // Data bus output
    output logic data_oe_n, // Data bus enable, low drives
    output logic wait_request_n, // Wait, low inserts waits
    input wire logic bus_16bit, // Width strap, high for 16 bit
    input wire logic [`DPH_RDS_W-1:0] ready_delay_setting, // Data to ready
    input wire logic spi_cs_n, // Serial select
    input wire logic spi_sclk, // Serial clock, sampled
    input wire logic spi_mosi, // Serial data in
    output logic spi_miso, // Serial data out
    output logic spi_miso_oe_n, // Serial out enable, low drives
    input wire logic spi_cpol, // Serial clock polarity
    input wire logic spi_cpha, // Serial clock phase
    input wire logic int_req, // Internal side request
    input wire logic int_we, // Internal side write
    input wire logic [1:0] int_be, // Internal side byte enables
    input wire logic [AW-2:0] int_addr, // Internal side word address
    input wire logic [DW-1:0] int_wdata, // Internal side write data
    output logic int_gnt, // Internal side granted
    output logic [DW-1:0] int_rdata // Internal read data, next cycle
);
    import dph_pkg::*;

    localparam int HB = DW / 2;

    ////////////////////////////////////////////////////////////////////////
    // Parallel cycle decode
    logic wr_act;
    logic rd_act;
    logic [1:0] lane_be;
    logic [DW-1:0] lane_wdata;
    dph_gnt_e gnt;
    logic [DW-1:0] ram_rdata;

    // Read framed by strobe or by select alike
    assign wr_act = !chip_select_n && !write_strobe_n;
    assign rd_act = !chip_select_n && !read_strobe_n && write_strobe_n;

    // Lane decode; enable ignored on an 8-bit bus
    always_comb begin
        if (!bus_16bit) begin
            lane_be = low_address_bit ? `DPH_BE_HIGH : `DPH_BE_LOW;
            lane_wdata = {data_in[HB-1:0], data_in[HB-1:0]};
        end else begin
            lane_wdata = data_in;
            case ({byte_high_enable_n, low_address_bit})
                2'b00: lane_be = `DPH_BE_WORD;
                2'b01: lane_be = `DPH_BE_HIGH;
                2'b10: lane_be = `DPH_BE_LOW;
                default: lane_be = `DPH_BE_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Posted write buffer
    logic wr_act_q, next_wr_act_q;
    logic wr_end;
    logic [AW-2:0] cap_addr, next_cap_addr;
    logic [1:0] cap_be, next_cap_be;
    logic [DW-1:0] cap_wdata, next_cap_wdata;
    logic pw_valid, next_pw_valid;
    logic [AW-2:0] pw_addr, next_pw_addr;
    logic [1:0] pw_be, next_pw_be;
    logic [DW-1:0] pw_wdata, next_pw_wdata;

    assign wr_end = wr_act_q && !wr_act;

    // Track the last strobed values; only the strobe's end posts them
    always_comb begin
        next_wr_act_q = wr_act;
        next_cap_addr = wr_act ? address : cap_addr;
        next_cap_be = wr_act ? lane_be : cap_be;
        next_cap_wdata = wr_act ? lane_wdata : cap_wdata;
        next_pw_valid = pw_valid;
        next_pw_addr = pw_addr;
        next_pw_be = pw_be;
        next_pw_wdata = pw_wdata;
        if (gnt == DPH_GNT_PW) begin
            next_pw_valid = 1'b0;
        end
        // A write ended over a busy buffer is lost, as wait was ignored
        if (wr_end && !pw_valid && cap_be != `DPH_BE_NONE) begin
            next_pw_valid = 1'b1;
            next_pw_addr = cap_addr;
            next_pw_be = cap_be;
            next_pw_wdata = cap_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_act_q <= 1'b0;
            cap_addr <= '0;
            cap_be <= `DPH_BE_NONE;
            cap_wdata <= '0;
            pw_valid <= 1'b0;
            pw_addr <= '0;
            pw_be <= `DPH_BE_NONE;
            pw_wdata <= '0;
        end else begin
            wr_act_q <= next_wr_act_q;
            cap_addr <= next_cap_addr;
            cap_be <= next_cap_be;
            cap_wdata <= next_cap_wdata;
            pw_valid <= next_pw_valid;
            pw_addr <= next_pw_addr;
            pw_be <= next_pw_be;
            pw_wdata <= next_pw_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parallel read sequencer
    dph_rd_e rd_state, next_rd_state;
    logic [`DPH_RDS_W-1:0] rd_cnt, next_rd_cnt;
    logic rd_ret, next_rd_ret;
    logic [DW-1:0] next_data_out;
    logic rd_ready;

    // Ready may release in the very cycle data turns valid
    assign rd_ready = (rd_state == DPH_RD_DONE) ||
        (rd_state == DPH_RD_DLY && !rd_ret &&
         rd_cnt == ready_delay_setting);

    // Hold wait from cycle start until the set delay past data valid or buffer free
    assign wait_request_n = !((wr_act && pw_valid) ||
                              (rd_act && !rd_ready));
    assign data_oe_n = !rd_act;

    always_comb begin
        next_rd_state = rd_state;
        next_rd_cnt = rd_cnt;
        next_rd_ret = (gnt == DPH_GNT_PRD);
        next_data_out = data_out;
        if (rd_ret) begin
            if (bus_16bit) begin
                next_data_out = ram_rdata;
            end else if (low_address_bit) begin
                next_data_out = {{HB{1'b0}}, ram_rdata[DW-1:HB]};
            end else begin
                next_data_out = {{HB{1'b0}}, ram_rdata[HB-1:0]};
            end
        end
        case (rd_state)
            DPH_RD_IDLE: begin
                if (rd_act) begin
                    next_rd_state = DPH_RD_MEM;
                end
            end
            DPH_RD_MEM: begin
                if (gnt == DPH_GNT_PRD) begin
                    next_rd_state = DPH_RD_DLY;
                    next_rd_cnt = '0;
                end
            end
            DPH_RD_DLY: begin
                if (rd_ready) begin
                    next_rd_state = DPH_RD_DONE;
                end else if (!rd_ret) begin
                    next_rd_cnt = rd_cnt + 1'b1;
                end
            end
            default: begin
            end
        endcase
        // Cycle ended or abandoned: back to idle
        if (!rd_act) begin
            next_rd_state = DPH_RD_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_state <= DPH_RD_IDLE;
            rd_cnt <= '0;
            rd_ret <= 1'b0;
            data_out <= '0;
        end else begin
            rd_state <= next_rd_state;
            rd_cnt <= next_rd_cnt;
            rd_ret <= next_rd_ret;
            data_out <= next_data_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial slave, mode chosen by polarity and phase
    dph_spi_e spi_state, next_spi_state;
    logic sclk_q, cs_q;
    logic sclk_rise, sclk_fall, smp_edge, shf_edge;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx_bits, next_rx_bits, rx_byte;
    logic [7:0] tx_bits, next_tx_bits;
    logic next_spi_miso;
    logic spi_we, next_spi_we;
    logic spi_req, next_spi_req;
    logic spi_ret;
    logic [AW-1:0] spi_addr, next_spi_addr;
    logic [7:0] spi_wdata, next_spi_wdata;

    assign sclk_rise = spi_sclk && !sclk_q;
    assign sclk_fall = !spi_sclk && sclk_q;
    // Modes 0 and 3 sample on rising, 1 and 2 on falling
    assign smp_edge = (spi_cpol ^ spi_cpha) ? sclk_fall : sclk_rise;
    assign shf_edge = (spi_cpol ^ spi_cpha) ? sclk_rise : sclk_fall;
    assign rx_byte = {rx_bits[6:0], spi_mosi};
    assign spi_miso_oe_n = spi_cs_n;

    // Command byte, address byte, then data with auto increment
    always_comb begin
        next_spi_state = spi_state;
        next_bit_cnt = bit_cnt;
        next_rx_bits = rx_bits;
        next_tx_bits = tx_bits;
        next_spi_miso = spi_miso;
        next_spi_we = spi_we;
        next_spi_req = spi_req;
        next_spi_addr = spi_addr;
        next_spi_wdata = spi_wdata;
        if (gnt == DPH_GNT_SPI) begin
            next_spi_req = 1'b0;
            next_spi_addr = spi_addr + 1'b1;
        end
        // Address already stepped past the fetched byte, so bit 0 is flipped
        if (spi_ret) begin
            next_tx_bits = spi_addr[0] ? ram_rdata[HB-1:0] :
                ram_rdata[DW-1:HB];
        end
        if (spi_cs_n) begin
            next_spi_state = DPH_SPI_CMD;
            next_bit_cnt = '0;
        end else if (smp_edge) begin
            next_rx_bits = rx_byte;
            next_tx_bits = {tx_bits[6:0], 1'b0};
            next_bit_cnt = bit_cnt + 1'b1;
            if (bit_cnt == `DPH_SPI_LAST_BIT) begin
                case (spi_state)
                    DPH_SPI_CMD: begin
                        next_spi_we = rx_byte[`DPH_SPI_WR_BIT];
                        next_spi_addr[AW-1:8] =
                            rx_byte[`DPH_SPI_AHI_W-1:0];
                        next_spi_state = DPH_SPI_ADDR;
                    end
                    DPH_SPI_ADDR: begin
                        next_spi_addr[7:0] = rx_byte;
                        next_spi_req = !spi_we; // Prefetch first byte
                        next_spi_state = DPH_SPI_DATA;
                    end
                    default: begin
                        next_spi_wdata = rx_byte;
                        next_spi_req = 1'b1;
                    end
                endcase
            end
        end
        // Present the next bit on the shift edge or at select
        if (shf_edge || (cs_q && !spi_cs_n)) begin
            next_spi_miso = next_tx_bits[7];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_q <= `DPH_SPI_CPOL_DEF;
            cs_q <= 1'b1;
            spi_state <= DPH_SPI_CMD;
            bit_cnt <= '0;
            rx_bits <= '0;
            tx_bits <= '0;
            spi_miso <= 1'b0;
            spi_we <= 1'b0;
            spi_req <= 1'b0;
            spi_ret <= 1'b0;
            spi_addr <= '0;
            spi_wdata <= '0;
        end else begin
            sclk_q <= spi_sclk;
            cs_q <= spi_cs_n;
            spi_state <= next_spi_state;
            bit_cnt <= next_bit_cnt;
            rx_bits <= next_rx_bits;
            tx_bits <= next_tx_bits;
            spi_miso <= next_spi_miso;
            spi_we <= next_spi_we;
            spi_req <= next_spi_req;
            spi_ret <= (gnt == DPH_GNT_SPI) && !spi_we;
            spi_addr <= next_spi_addr;
            spi_wdata <= next_spi_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory arbitration, internal side first, host reads last
    logic ram_en, ram_we;
    logic [1:0] ram_be;
    logic [AW-2:0] ram_addr;
    logic [DW-1:0] ram_wdata;

    always_comb begin
        gnt = DPH_GNT_NONE;
        ram_we = 1'b0;
        ram_be = `DPH_BE_NONE;
        ram_addr = '0;
        ram_wdata = '0;
        if (int_req) begin
            gnt = DPH_GNT_INT;
            ram_we = int_we;
            ram_be = int_be;
            ram_addr = int_addr;
            ram_wdata = int_wdata;
        end else if (spi_req) begin
            gnt = DPH_GNT_SPI;
            ram_we = spi_we;
            ram_be = spi_addr[0] ? `DPH_BE_HIGH : `DPH_BE_LOW;
            ram_addr = spi_addr[AW-1:1];
            ram_wdata = {spi_wdata, spi_wdata};
        end else if (pw_valid) begin
            gnt = DPH_GNT_PW;
            ram_we = 1'b1;
            ram_be = pw_be;
            ram_addr = pw_addr;
            ram_wdata = pw_wdata;
        end else if (rd_state == DPH_RD_MEM) begin
            // Reads wait behind the posted write to keep order
            gnt = DPH_GNT_PRD;
            ram_addr = address;
        end
    end

    assign ram_en = (gnt != DPH_GNT_NONE);
    assign int_gnt = (gnt == DPH_GNT_INT);
    assign int_rdata = ram_rdata;

    dph_ram #(
        .AW(AW - 1),
        .DW(DW)
    ) dph_ram_i (
        .clk(clk),
        .en(ram_en),
        .we(ram_we),
        .be(ram_be),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [3:0] since_data;

    // Cycles since read data reached the bus, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            since_data <= '0;
        end else if (rd_ret) begin
            since_data <= '0;
        end else if (since_data != 4'hf) begin
            since_data <= since_data + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_wr_post;
        wr_end && !pw_valid && cap_be != `DPH_BE_NONE |=> pw_valid;
    endproperty
    a_wr_post: assert property (p_wr_post)
        else $error("ended write not posted");

    property p_wr_wait;
        wr_act && pw_valid |-> !wait_request_n;
    endproperty
    a_wr_wait: assert property (p_wr_wait)
        else $error("no wait over pending write");

    property p_cs_frame;
        $fell(chip_select_n) && !read_strobe_n && write_strobe_n &&
            rd_state == DPH_RD_IDLE |=> rd_state == DPH_RD_MEM;
    endproperty
    a_cs_frame: assert property (p_cs_frame)
        else $error("select framed read not started");

    property p_rd_delay;
        rd_act && $rose(wait_request_n) |-> !rd_ret &&
            since_data == {1'b0, ready_delay_setting};
    endproperty
    a_rd_delay: assert property (p_rd_delay)
        else $error("ready not at programmed data delay");

    property p_spi_wr;
        gnt == DPH_GNT_SPI && spi_we |-> ram_we &&
            ram_wdata[HB-1:0] == spi_wdata;
    endproperty
    a_spi_wr: assert property (p_spi_wr)
        else $error("serial write data lost");

    property p_spi_mode3;
        !spi_cs_n && spi_cpol && spi_cpha && sclk_rise |=>
            rx_bits[0] == $past(spi_mosi);
    endproperty
    a_spi_mode3: assert property (p_spi_mode3)
        else $error("mode 3 not sampled on rising clock");

    property p_lane8;
        rd_ret && !bus_16bit |=> data_out[DW-1:HB] == '0;
    endproperty
    a_lane8: assert property (p_lane8)
        else $error("8-bit read drives upper lane");

    property p_no_access;
        wr_act && bus_16bit && byte_high_enable_n && low_address_bit
            |=> cap_be == `DPH_BE_NONE;
    endproperty
    a_no_access: assert property (p_no_access)
        else $error("no-access lane code writes bytes");

    property p_rd_start;
        $rose(rd_act) |-> !wait_request_n ##1 !wait_request_n;
    endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("wait not held at read start");
endmodule

// [sim/dph_host_model.sv]
`timescale 1ns/10ps

// Host processor: parallel bus and serial master
module dph_host_model (
    input wire logic clk, // System clock
    input wire logic wait_request_n, // Wait from device
    input wire logic [15:0] data_out, // Read data
    input wire logic spi_miso, // Serial data out
    output logic chip_select_n, // Chip select
    output logic read_strobe_n, // Read strobe
    output logic write_strobe_n, // Write strobe
    output logic byte_high_enable_n, // High byte enable
    output logic low_address_bit, // Byte address bit 0
    output logic [13:1] address, // Word address
    output logic [15:0] data_in, // Write data
    output logic spi_cs_n, // Serial select
    output logic spi_sclk, // Serial clock
    output logic spi_mosi // Serial data in
);
    // Idle levels; serial clock parks high
    initial begin
        chip_select_n = 1'h1;
        read_strobe_n = 1'h1;
        write_strobe_n = 1'h1;
        byte_high_enable_n = 1'h1;
        low_address_bit = 1'h0;
        address = 13'h0;
        data_in = 16'h0;
        spi_cs_n = 1'h1;
        spi_sclk = 1'h1;
        spi_mosi = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Judged mid-cycle so the taking edge never races the device
    task automatic hold(output int waits);
        waits = 0;
        @(negedge clk);
        while (wait_request_n !== 1'h1 && waits < 500) begin
            waits++;
            @(negedge clk);
        end
    endtask

    task automatic par_write(input logic [13:1] a, input logic [1:0] lane,
            input logic [15:0] d, output int waits);
        @(posedge clk);
        #1;
        address = a;
        {byte_high_enable_n, low_address_bit} = lane;
        data_in = d;
        chip_select_n = 1'h0;
        write_strobe_n = 1'h0;
        hold(waits);
        @(posedge clk);
        #1;
        write_strobe_n = 1'h1;
        chip_select_n = 1'h1;
        data_in = ~d; // Released bus shows no stale value
    endtask

    // Select framing asserts a clock after the strobe; strobe framing asserts with select; the framing signal releases first
    task automatic par_read(input logic [13:1] a, input logic [1:0] lane,
            input logic by_cs, output logic [15:0] d, output int waits);
        @(posedge clk);
        #1;
        address = a;
        {byte_high_enable_n, low_address_bit} = lane;
        read_strobe_n = 1'h0;
        chip_select_n = by_cs;
        if (by_cs) begin
            @(posedge clk);
            #1;
            chip_select_n = 1'h0;
        end
        hold(waits);
        d = data_out;
        @(posedge clk);
        #1;
        if (by_cs) chip_select_n = 1'h1;
        else read_strobe_n = 1'h1;
        @(posedge clk);
        #1;
        chip_select_n = 1'h1;
        read_strobe_n = 1'h1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Eight system clocks per half bit keeps sampling safe
    task automatic half;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic spi_frame(input logic [7:0] tx [4],
            output logic [7:0] rx [4]);
        @(posedge clk);
        #1;
        spi_cs_n = 1'h0;
        half;
        for (int b = 0; b < 4; b++) begin
            for (int i = 7; i >= 0; i--) begin
                spi_sclk = 1'h0; // Shift on falling edge
                spi_mosi = tx[b][i];
                half;
                spi_sclk = 1'h1;
                rx[b][i] = spi_miso;
                half;
            end
        end
        spi_cs_n = 1'h1;
        spi_mosi = 1'h1;
        half;
    endtask
endmodule

// [sim/dph_port_tb.sv]
`timescale 1ns/10ps
`include "dph_defs.svh"

`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("ERROR %s expected %h seen %h", what, exp, got); \
        end \
    end

module dph_port_tb;
    logic clk, reset_n, bus_16bit, spi_cpol, spi_cpha;
    logic cs_n, rd_n, wr_n, bhe_n, a0, spi_cs_n, sclk, mosi, miso;
    logic int_req, int_we, int_gnt, wait_n, oe_n, miso_oe_n;
    logic [2:0] rds;
    logic [1:0] int_be;
    logic [13:1] addr;
    logic [12:0] int_addr;
    logic [15:0] din, dout, int_wdata, int_rdata;
    int num_errors = 0;
    int checks_done = 0;

    // Clock at 250 MHz
    initial clk = 1'h0;
    always #2 clk = ~clk;

    dph_port dph_port_i (.clk(clk), .reset_n(reset_n),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .byte_high_enable_n(bhe_n), .low_address_bit(a0), .address(addr),
        .data_in(din), .data_out(dout), .data_oe_n(oe_n),
        .wait_request_n(wait_n), .bus_16bit(bus_16bit),
        .ready_delay_setting(rds), .spi_cs_n(spi_cs_n), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n),
        .spi_cpol(spi_cpol), .spi_cpha(spi_cpha), .int_req(int_req),
        .int_we(int_we), .int_be(int_be), .int_addr(int_addr),
        .int_wdata(int_wdata), .int_gnt(int_gnt), .int_rdata(int_rdata));

    dph_host_model dph_host_model_i (.clk(clk), .wait_request_n(wait_n),
        .data_out(dout), .spi_miso(miso), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .byte_high_enable_n(bhe_n), .low_address_bit(a0), .address(addr),
        .data_in(din), .spi_cs_n(spi_cs_n), .spi_sclk(sclk),
        .spi_mosi(mosi));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Word, then each lane code, read back by both framings
    task automatic t_word;
        logic [15:0] d;
        int w;
        logic [1:0] ln [3] = '{2'b01, 2'b10, 2'b11};
        logic [15:0] wd [3] = '{16'hab00, 16'h00cd, 16'hffff};
        logic [15:0] ex [3] = '{16'hab34, 16'habcd, 16'habcd};
        dph_host_model_i.par_write(13'h10, 2'b00, 16'h1234, w);
        `CHK("idle write waits", 0, w)
        `CHK("bus idle", 1'h1, oe_n)
        fork
            dph_host_model_i.par_read(13'h10, 2'b00, 1'h0, d, w);
            begin
                repeat (2) @(posedge clk);
                #1;
                `CHK("bus driven in read", 1'h0, oe_n)
            end
        join
        `CHK("word read", 16'h1234, d)
        for (int i = 0; i < 3; i++) begin
            dph_host_model_i.par_write(13'h10, ln[i], wd[i], w);
            dph_host_model_i.par_read(13'h10, 2'b00, i[0], d, w);
            `CHK("lane read", ex[i], d)
        end
        $display("t_word done");
    endtask

    // Wait stretch grows one clock per step of the setting
    task automatic t_delay;
        logic [15:0] d;
        int w0, w;
        logic [2:0] st [2] = '{3'h3, 3'h7};
        rds = 3'h0;
        dph_host_model_i.par_read(13'h10, 2'b00, 1'h0, d, w0);
        for (int i = 0; i < 2; i++) begin
            rds = st[i];
            dph_host_model_i.par_read(13'h10, 2'b00, 1'h1, d, w);
            `CHK("ready delay", int'(st[i]), w - w0)
            `CHK("delayed data", 16'habcd, d)
        end
        rds = 3'h0;
        $display("t_delay done");
    endtask

    // Internal side holds memory so the posted write cannot land
    task automatic t_posted;
        logic [15:0] d;
        int wa, wb;
        int_req = 1'h1;
        dph_host_model_i.par_write(13'h20, 2'b00, 16'h0f0f, wa);
        fork
            dph_host_model_i.par_write(13'h21, 2'b00, 16'hf0f0, wb);
            begin
                repeat (12) @(posedge clk);
                #1;
                int_req = 1'h0;
            end
        join
        `CHK("first write waits", 0, wa)
        `CHK("second write waited", 1'h1, wb > 5)
        dph_host_model_i.par_read(13'h20, 2'b00, 1'h0, d, wa);
        `CHK("posted first", 16'h0f0f, d)
        dph_host_model_i.par_read(13'h21, 2'b00, 1'h1, d, wa);
        `CHK("posted second", 16'hf0f0, d)
        $display("t_posted done");
    endtask

    // Narrow bus ignores the high enable
    task automatic t_byte8;
        logic [15:0] d;
        int w;
        bus_16bit = 1'h0;
        dph_host_model_i.par_write(13'h22, 2'b11, 16'hff5a, w);
        dph_host_model_i.par_write(13'h22, 2'b00, 16'hffc3, w);
        dph_host_model_i.par_read(13'h22, 2'b01, 1'h0, d, w);
        `CHK("byte8 high", 16'h005a, d)
        dph_host_model_i.par_read(13'h22, 2'b10, 1'h1, d, w);
        `CHK("byte8 low", 16'h00c3, d)
        bus_16bit = 1'h1;
        dph_host_model_i.par_read(13'h22, 2'b00, 1'h0, d, w);
        `CHK("byte8 word", 16'h5ac3, d)
        $display("t_byte8 done");
    endtask

    // Serial write then read, low byte first
    task automatic t_spi;
        logic [15:0] d;
        int w;
        logic [7:0] rx [4];
        dph_host_model_i.spi_frame('{8'h82, 8'h60, 8'h11, 8'h22}, rx);
        repeat (20) @(posedge clk);
        dph_host_model_i.par_read(13'h130, 2'b00, 1'h0, d, w);
        `CHK("serial write", 16'h2211, d)
        fork
            dph_host_model_i.spi_frame('{8'h00, 8'h20, 8'h00, 8'h00}, rx);
            begin
                repeat (4) @(posedge clk);
                #1;
                `CHK("serial out driven", 1'h0, miso_oe_n)
            end
        join
        `CHK("serial out released", 1'h1, miso_oe_n)
        `CHK("serial read low", 8'hcd, rx[2])
        `CHK("serial read high", 8'hab, rx[3])
        $display("t_spi done");
    endtask

    task automatic int_access(input logic we, input logic [12:0] a,
            input logic [15:0] d);
        @(posedge clk);
        #1;
        int_req = 1'h1;
        int_we = we;
        int_addr = a;
        int_wdata = d;
        int_be = `DPH_BE_WORD;
        @(negedge clk);
        `CHK("grant", 1'h1, int_gnt)
        @(posedge clk);
        #1;
        int_req = 1'h0;
    endtask

    // Both ports see the same memory
    task automatic t_int;
        logic [15:0] d;
        int w;
        int_access(1'h1, 13'h40, 16'hbeef);
        dph_host_model_i.par_read(13'h40, 2'b00, 1'h0, d, w);
        `CHK("internal write", 16'hbeef, d)
        int_access(1'h0, 13'h10, 16'h0);
        `CHK("internal read", 16'habcd, int_rdata)
        $display("t_int done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n = 1'h0;
        bus_16bit = 1'h1;
        rds = 3'h0;
        spi_cpol = `DPH_SPI_CPOL_DEF;
        spi_cpha = `DPH_SPI_CPHA_DEF;
        int_req = 1'h0;
        int_we = 1'h0;
        int_be = 2'h0;
        int_addr = 13'h0;
        int_wdata = 16'h0;
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'h1;
        t_word;
        t_delay;
        t_posted;
        t_byte8;
        t_spi;
        t_int;
        conclude;
    end

    // Watchdog, well beyond the roughly 1250 clocks expected
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("ERROR watchdog expected done seen hang");
        conclude;
    end
endmodule
